// >>> design/usb_status_interrupt_logic.sv
// Purpose: Top-level USB status flags, enables, interrupt request and descriptor table
// Assumes: Engine strobes are one-cycle pulses on clk_sys; D+/D- arrive asynchronously
// Notes: Descriptor bytes have no reset value; all control state resets to zero
//
// Behaviour
// - Firmware-owned status bits 3:2 hold check/stall settings
// - Engine writes last token identifier into bits 5:2
// - Expected toggle ignored unless check enable set
// - 32 descriptors of four unreset bytes
// - All sources merge into one interrupt request
// - Enabled error sources raise error summary flag
// - Error summary flag ignores software writes
// - Flags ORed into request, each with enable
// - Flags other than the error summary stay set until written zero
// - Writing one sets a writable flag
// - Start-of-frame token sets bit 6
// - Sent stall handshake sets bit 5
// - Idle for 3 ms sets bit 4
// - Finished transaction sets bit 3
// - Clearing bit 3 advances transaction status FIFO
// - D+/D- activity sets bit 2
// - Bus reset sets bit 0, clears address
// - Bit 7 reads zero, flags reset zero
// - Enables gate only the request, not flags
// - One activity event per resume from idle
// - Status bit 7 set means engine owns
`timescale 1ns/1ns
`include "usb_status_defs.svh"

module usb_status_interrupt_logic #(
  parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire usb_status_pkg::engine_event_t eng,
  input wire logic [7:0] err_flags,
  input wire logic [7:0] err_enable,
  output usb_status_pkg::descriptor_view_t bd_view,
  output logic fifo_advance,
  output logic [6:0] device_address,
  output logic peripheral_interrupt_request
);

  localparam int CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] QUIET_LAST = CW'(IDLE_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] QUIET_FULL = CW'(IDLE_CYCLES);

  if (IDLE_CYCLES < 2) begin : g_bad_idle
    $error("IDLE_CYCLES must be at least 2");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [6:0] bd_byte(input logic [4:0] idx, input logic [1:0] b);
    bd_byte = {idx, b};
  endfunction

  // Register state
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] ev_vec;
  logic [7:0] en_q;
  logic [6:0] addr_q;
  logic [7:0] rdata_q;
  logic adv_q;
  logic [7:0] flag_view;
  logic err_summary;
  logic wr_flags;
  logic wr_enable;
  logic wr_devaddr;
  logic wr_bd;

  // Descriptor table, 4 bytes per entry: status, count, address low, address high
  logic [7:0] bd_mem [0:127];
  usb_status_pkg::descriptor_view_t view_q;
  logic [7:0] sel_status;

  // Line monitor
  logic [1:0] line_s1_q;
  logic [1:0] line_s2_q;
  logic j_now;
  usb_status_pkg::line_state_t line_q;
  logic [CW-1:0] quiet_cnt_q;
  logic idle_ev;
  logic act_ev;
  logic act_armed_q;
  logic [CW-1:0] j_run_q;

  assign wr_flags = reg_wr && hit(reg_addr, `OFF_FLAGS);
  assign wr_enable = reg_wr && hit(reg_addr, `OFF_ENABLE);
  assign wr_devaddr = reg_wr && hit(reg_addr, `OFF_DEVADDR);
  assign wr_bd = reg_wr && !reg_addr[7];

  assign err_summary = |(err_flags & err_enable);

  // summary bit is live, never stored
  always_comb begin
    flag_view = flags_q & `FLAG_WMASK;
    flag_view[`BIT_ERR] = err_summary;
  end

  // Two flops before any logic looks at the bus lines
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      line_s1_q <= 2'h0;
      line_s2_q <= 2'h0;
    end else if (clk_en) begin
      line_s1_q <= {line_dm, line_dp};
      line_s2_q <= line_s1_q;
    end
  end

  assign j_now = (line_s2_q == `LINE_J);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      line_q <= usb_status_pkg::LINE_ACTIVE;
      quiet_cnt_q <= '0;
    end else if (clk_en) begin
      unique case (line_q)
        usb_status_pkg::LINE_ACTIVE: begin
          quiet_cnt_q <= '0;
          if (j_now) begin
            line_q <= usb_status_pkg::LINE_QUIET;
          end
        end
        usb_status_pkg::LINE_QUIET: begin
          if (!j_now) begin
            line_q <= usb_status_pkg::LINE_ACTIVE;
            quiet_cnt_q <= '0;
          end else if (quiet_cnt_q == QUIET_LAST) begin
            line_q <= usb_status_pkg::LINE_IDLE;
          end else begin
            quiet_cnt_q <= quiet_cnt_q + CNT_ONE;
          end
        end
        usb_status_pkg::LINE_IDLE: begin
          quiet_cnt_q <= '0;
          if (!j_now) begin
            line_q <= usb_status_pkg::LINE_ACTIVE;
          end
        end
        default: begin
          line_q <= usb_status_pkg::LINE_ACTIVE;
          quiet_cnt_q <= '0;
        end
      endcase
    end
  end

  assign idle_ev = (line_q == usb_status_pkg::LINE_QUIET) && j_now &&
                   (quiet_cnt_q == QUIET_LAST);

  // any non-idle line state after an idle counts as activity
  assign act_ev = act_armed_q && !j_now;

  // one activity event per idle period
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      act_armed_q <= 1'b0;
    end else if (clk_en) begin
      if (idle_ev) begin
        act_armed_q <= 1'b1;
      end else if (act_ev) begin
        act_armed_q <= 1'b0;
      end
    end
  end

  // frame start, stall, idle, transaction, activity, bus reset
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[`BIT_SOF] = eng.sof;
    ev_vec[`BIT_STALL] = eng.stall_sent;
    ev_vec[`BIT_IDLE] = idle_ev;
    ev_vec[`BIT_TRN] = eng.trn_done;
    ev_vec[`BIT_ACT] = act_ev;
    ev_vec[`BIT_BUSRST] = eng.bus_reset;
  end

  // write zero clears, write one sets
  // set regardless of enables; a same-cycle event beats a clear
  always_comb begin
    flags_d = wr_flags ? (reg_wdata & `FLAG_WMASK) : flags_q;
    flags_d = flags_d | ev_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags_q <= `FLAG_RESET;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  // clearing a set transaction flag pops the status FIFO
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      adv_q <= 1'b0;
    end else if (clk_en) begin
      adv_q <= wr_flags && flags_q[`BIT_TRN] && !reg_wdata[`BIT_TRN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      en_q <= `ENABLE_RESET;
    end else if (clk_en && wr_enable) begin
      en_q <= reg_wdata & `ENABLE_WMASK;
    end
  end

  // bus reset wins over a software address write
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      addr_q <= `DEVADDR_RESET;
    end else if (clk_en) begin
      if (eng.bus_reset) begin
        addr_q <= `DEVADDR_RESET;
      end else if (wr_devaddr) begin
        addr_q <= reg_wdata[6:0];
      end
    end
  end

  // write-back only into an engine-owned entry; it also hands it back
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_bd) begin
        bd_mem[reg_addr[6:0]] <= reg_wdata;
      end
      if (eng.wb_valid && bd_mem[bd_byte(eng.wb_index, 2'h0)][`BD_OWN]) begin
        bd_mem[bd_byte(eng.wb_index, 2'h0)] <= {1'b0,
          bd_mem[bd_byte(eng.wb_index, 2'h0)][`BD_TOGGLE], eng.wb_pid, eng.wb_count[9:8]};
        bd_mem[bd_byte(eng.wb_index, 2'h1)] <= eng.wb_count[7:0];
      end
    end
  end

  // ownership bit; check/stall bits read from firmware setup
  // toggle masked unless checking is enabled
  assign sel_status = bd_mem[bd_byte(eng.sel_index, 2'h0)];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      view_q <= '0;
    end else if (clk_en) begin
      view_q.owned <= sel_status[`BD_OWN];
      view_q.toggle_check_enable <= sel_status[`BD_CHECK];
      view_q.expected_toggle <= sel_status[`BD_TOGGLE] & sel_status[`BD_CHECK];
      view_q.stall_request <= sel_status[`BD_STALL];
      view_q.byte_count <= {sel_status[1:0], bd_mem[bd_byte(eng.sel_index, 2'h1)]};
      view_q.buffer_address <= {bd_mem[bd_byte(eng.sel_index, 2'h3)],
                                bd_mem[bd_byte(eng.sel_index, 2'h2)]};
    end
  end

  // Read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (!reg_rd) begin
        rdata_q <= 8'h00;
      end else if (!reg_addr[7]) begin
        rdata_q <= bd_mem[reg_addr[6:0]];
      end else if (hit(reg_addr, `OFF_FLAGS)) begin
        rdata_q <= flag_view;
      end else if (hit(reg_addr, `OFF_ENABLE)) begin
        rdata_q <= en_q;
      end else if (hit(reg_addr, `OFF_DEVADDR)) begin
        rdata_q <= {1'b0, addr_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // each flag gated by its enable, ORed every cycle
  assign peripheral_interrupt_request = |(flag_view & en_q);

  assign reg_rdata = rdata_q;
  assign bd_view = view_q;
  assign fifo_advance = adv_q;
  assign device_address = addr_q;

  // Independent run length of J samples, so the idle check does not trust the timer
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      j_run_q <= '0;
    end else if (clk_en) begin
      if (!j_now) begin
        j_run_q <= '0;
      end else if (j_run_q != QUIET_FULL) begin
        j_run_q <= j_run_q + CNT_ONE;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence trn_clear_s;
    clk_en && wr_flags && flags_q[`BIT_TRN] && !reg_wdata[`BIT_TRN];
  endsequence

  sequence idle_reached_s;
    clk_en && (line_q == usb_status_pkg::LINE_QUIET) && j_now &&
      (quiet_cnt_q == QUIET_LAST);
  endsequence

  sequence flag_read_s;
    clk_en && reg_rd && hit(reg_addr, `OFF_FLAGS);
  endsequence

  sof_flag_set_a: assert property (clk_en && eng.sof |=> flags_q[`BIT_SOF])
    else $error("frame start flag not set");

  stall_flag_set_a: assert property (clk_en && eng.stall_sent |=> flags_q[`BIT_STALL])
    else $error("stall flag not set");

  trn_flag_set_a: assert property (clk_en && eng.trn_done |=> flags_q[`BIT_TRN])
    else $error("transaction flag not set");

  fifo_pop_a: assert property (trn_clear_s |=> fifo_advance ##1 (!fifo_advance ||
    $past(!clk_en || (wr_flags && flags_q[`BIT_TRN] && !reg_wdata[`BIT_TRN]))))
    else $error("clearing transaction flag did not advance FIFO");

  idle_flag_timer_a: assert property (idle_reached_s |=> flags_q[`BIT_IDLE] &&
    line_q == usb_status_pkg::LINE_IDLE)
    else $error("idle flag not set after quiet period");

  idle_too_early_a: assert property (clk_en && idle_ev |->
    j_run_q == QUIET_FULL && $past(line_s2_q) == `LINE_J)
    else $error("idle flagged before quiet period elapsed");

  bus_reset_addr_a: assert property (clk_en && eng.bus_reset |=>
    flags_q[`BIT_BUSRST] && device_address == 7'h00)
    else $error("bus reset did not set flag or clear address");

  sw_clear_flag_a: assert property (clk_en && wr_flags && !reg_wdata[`BIT_SOF] &&
    !eng.sof |=> !flags_q[`BIT_SOF])
    else $error("writing zero did not clear flag");

  sw_set_flag_a: assert property (clk_en && wr_flags && reg_wdata[`BIT_STALL] |=>
    flags_q[`BIT_STALL])
    else $error("writing one did not set flag");

  err_summary_ro_a: assert property (flag_read_s |=>
    reg_rdata[`BIT_ERR] == $past(err_summary) && !reg_rdata[7])
    else $error("error summary or bit 7 read back wrong");

  activity_once_a: assert property (clk_en && !act_armed_q && !flags_q[`BIT_ACT] &&
    !(wr_flags && reg_wdata[`BIT_ACT]) |=> !flags_q[`BIT_ACT])
    else $error("activity flag set without a preceding idle");

  toggle_mask_a: assert property (!bd_view.toggle_check_enable |->
    !bd_view.expected_toggle)
    else $error("expected toggle visible while checking disabled");

  pid_writeback_a: assert property (clk_en && eng.wb_valid &&
    bd_mem[bd_byte(eng.wb_index, 2'h0)][`BD_OWN] |=>
    bd_mem[bd_byte($past(eng.wb_index), 2'h0)][5:2] == $past(eng.wb_pid))
    else $error("token identifier not written back");

  irq_enable_a: assert property (clk_en && wr_enable && !wr_flags &&
    |(reg_wdata & flags_q & `FLAG_WMASK) |=> peripheral_interrupt_request)
    else $error("enabled flag did not raise the request");

endmodule // usb_status_interrupt_logic

// >>> dv/test_usb_status_interrupt_logic.sv
// Purpose: Self-checking bench for the USB status flags and descriptor table
// Assumes: Idle count shortened to IDLE_N cycles
// Notes: Flag and enable model kept in bench variables
`timescale 1ns/1ns
`include "usb_status_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_usb_status_interrupt_logic;
  localparam int IDLE_N = 20;
  logic clk_sys, rstn, clk_en, reg_wr, reg_rd, line_dp, line_dm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, err_flags, err_enable, rv, st;
  logic fifo_advance, peripheral_interrupt_request;
  logic [6:0] device_address;
  logic [7:0] flags_m, en_m;
  logic [4:0] idx;
  logic [3:0] token_identifier;
  logic [9:0] cnt;
  logic [15:0] ba;
  logic [7:0] cb;
  usb_status_pkg::engine_event_t eng;
  usb_status_pkg::descriptor_view_t bd_view;
  int num_errors = 0;
  int check_count = 0;
  int seed = 32'h9104;
  int evbit[4] = '{6, 5, 3, 0};
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  usb_status_interrupt_logic #(.IDLE_CYCLES(IDLE_N)) i_usb_status_interrupt_logic (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_dp(line_dp), .line_dm(line_dm), .eng(eng), .err_flags(err_flags),
    .err_enable(err_enable), .bd_view(bd_view), .fifo_advance(fifo_advance),
    .device_address(device_address),
    .peripheral_interrupt_request(peripheral_interrupt_request));
  usb_engine_model i_usb_engine_model (
    .clk_sys(clk_sys), .eng(eng), .line_dp(line_dp), .line_dm(line_dm));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask
  task automatic chk_flags;
    logic e;
    e = |(err_flags & err_enable);
    rd(`OFF_FLAGS);
    `CHK(rv, flags_m | {6'h00, e, 1'b0})
    `CHK(peripheral_interrupt_request, |(en_m & (flags_m | {6'h00, e, 1'b0})))
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    report_and_stop;
  end
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, err_flags, err_enable} = '0;
    clk_en = 1'b1;
    flags_m = 8'h00;
    en_m = 8'h00;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    chk_flags;
    rd(`OFF_ENABLE);
    `CHK(rv, 8'h00)
    rd(8'h90);
    `CHK(rv, 8'h00)
    $display("test reset done");
    wr(`OFF_FLAGS, 8'hff);
    flags_m = 8'h7d;
    chk_flags;
    wr(`OFF_FLAGS, 8'hf7);
    @(negedge clk_sys);
    `CHK(fifo_advance, 1'b1)
    @(negedge clk_sys);
    `CHK(fifo_advance, 1'b0)
    flags_m = 8'h75;
    chk_flags;
    wr(`OFF_FLAGS, 8'h00);
    @(negedge clk_sys);
    `CHK(fifo_advance, 1'b0)
    flags_m = 8'h00;
    chk_flags;
    $display("test software flags done");
    wr(`OFF_DEVADDR, 8'h2a);
    rd(`OFF_DEVADDR);
    `CHK(rv, 8'h2a)
    for (int k = 0; k < 4; k++) begin
      en_m = k[0] ? 8'h7f : 8'h00;
      wr(`OFF_ENABLE, en_m);
      i_usb_engine_model.pulse(k);
      flags_m = 8'h01 << evbit[k];
      chk_flags;
      wr(`OFF_FLAGS, 8'h00);
      flags_m = 8'h00;
    end
    `CHK(device_address, 7'h00)
    $display("test engine events done");
    en_m = 8'h02;
    wr(`OFF_ENABLE, en_m);
    for (int k = 0; k < 8; k++) begin
      err_flags <= 8'($random(seed));
      err_enable <= 8'($random(seed));
      wr(`OFF_FLAGS, k[0] ? 8'h02 : 8'h00);
      chk_flags;
    end
    err_flags <= 8'h00;
    $display("test error summary done");
    en_m = 8'h10;
    wr(`OFF_ENABLE, en_m);
    i_usb_engine_model.set_traffic(1'b0);
    repeat (IDLE_N - 2) @(posedge clk_sys);
    chk_flags;
    repeat (10) @(posedge clk_sys);
    flags_m = 8'h10;
    chk_flags;
    // firmware unmasks activity only after quiet is flagged
    en_m = 8'h14;
    wr(`OFF_ENABLE, en_m);
    i_usb_engine_model.set_traffic(1'b1);
    repeat (6) @(posedge clk_sys);
    flags_m = 8'h14;
    chk_flags;
    wr(`OFF_FLAGS, 8'h10);
    flags_m = 8'h10;
    repeat (10) @(posedge clk_sys);
    chk_flags;
    // A write with the clock enable low must leave every flag alone
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`OFF_FLAGS, 8'h00);
    clk_en <= 1'b1;
    chk_flags;
    $display("test idle and activity done");
    for (int k = 0; k < 4; k++) begin
      idx = (k == 0) ? 5'h1f : 5'($random(seed));
      st = {1'b0, 1'($random(seed)), 2'($random(seed)), k[0], k[1], 2'b00};
      // firmware rewrites check and stall before hand-over
      wr({idx, 2'b00}, st);
      cb = 8'($random(seed));
      ba = 16'($random(seed));
      wr({idx, 2'b01}, cb);
      wr({idx, 2'b10}, ba[7:0]);
      wr({idx, 2'b11}, ba[15:8]);
      i_usb_engine_model.select(idx);
      repeat (2) @(negedge clk_sys);
      `CHK(bd_view.expected_toggle, st[6] & st[3])
      `CHK({bd_view.toggle_check_enable, bd_view.stall_request}, st[3:2])
      `CHK(bd_view.buffer_address, ba)
      `CHK(bd_view.byte_count, {st[1:0], cb})
      wr({idx, 2'b00}, st | 8'h80);
      repeat (2) @(negedge clk_sys);
      `CHK(bd_view.owned, 1'b1)
      token_identifier = 4'($random(seed));
      cnt = 10'($random(seed));
      i_usb_engine_model.write_back(idx, token_identifier, cnt);
      rd({idx, 2'b00});
      `CHK(rv, {1'b0, st[6], token_identifier, cnt[9:8]})
      i_usb_engine_model.write_back(idx, ~token_identifier, ~cnt);
      rd({idx, 2'b01});
      `CHK(rv, cnt[7:0])
    end
    $display("test descriptors done");
    report_and_stop;
  end
endmodule // test_usb_status_interrupt_logic

// >>> dv/usb_engine_model.sv
// Purpose: Engine and bus-line model feeding the status block's event inputs
// Assumes: Strobes launch just after a rising edge of clk_sys
// Notes: Traffic changes the lines every cycle so stale levels never look quiet
`timescale 1ns/1ns
module usb_engine_model (
  input wire logic clk_sys,
  output usb_status_pkg::engine_event_t eng,
  output logic line_dp,
  output logic line_dm
);
  logic traffic_q = 1'b1;
  initial begin
    eng = '0;
    line_dp = 1'b0;
    line_dm = 1'b0;
  end
  // Lines sit at J when quiet, alternate K and SE0 under traffic
  always @(posedge clk_sys) begin
    line_dp <= ~traffic_q;
    line_dm <= traffic_q & ~line_dm;
  end
  task automatic set_traffic(input bit on);
    @(posedge clk_sys);
    traffic_q <= on;
  endtask
  task automatic pulse(input int which);
    @(posedge clk_sys);
    case (which)
      0: eng.sof <= 1'b1;
      1: eng.stall_sent <= 1'b1;
      2: eng.trn_done <= 1'b1;
      default: eng.bus_reset <= 1'b1;
    endcase
    @(posedge clk_sys);
    {eng.sof, eng.stall_sent, eng.trn_done, eng.bus_reset} <= 4'h0;
  endtask
  task automatic write_back(input logic [4:0] idx, input logic [3:0] token_identifier,
                            input logic [9:0] cnt);
    @(posedge clk_sys);
    eng.wb_valid <= 1'b1;
    eng.wb_index <= idx;
    eng.wb_pid <= token_identifier;
    eng.wb_count <= cnt;
    @(posedge clk_sys);
    eng.wb_valid <= 1'b0;
  endtask
  task automatic select(input logic [4:0] idx);
    @(posedge clk_sys);
    eng.sel_index <= idx;
  endtask
endmodule // usb_engine_model

// >>> pkg/usb_status_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the USB status block
// Assumes: Byte-wide register port with an 8-bit address
// Notes: Descriptor bytes occupy offsets 8'h00 to 8'h7f, four per descriptor
`ifndef USB_STATUS_DEFS_SVH
`define USB_STATUS_DEFS_SVH
`define OFF_FLAGS 8'h80
`define OFF_ENABLE 8'h81
`define OFF_DEVADDR 8'h82
`define FLAG_WMASK 8'h7d
`define ENABLE_WMASK 8'h7f
`define FLAG_RESET 8'h00
`define ENABLE_RESET 8'h00
`define DEVADDR_RESET 7'h00
`define BIT_SOF 6
`define BIT_STALL 5
`define BIT_IDLE 4
`define BIT_TRN 3
`define BIT_ACT 2
`define BIT_ERR 1
`define BIT_BUSRST 0
`define BD_OWN 7
`define BD_TOGGLE 6
`define BD_CHECK 3
`define BD_STALL 2
`define LINE_J 2'h1
`define IDLE_TIME_US 3000
`define CLK_MHZ 20
`define IDLE_CYCLES (`IDLE_TIME_US * `CLK_MHZ)
`endif

// >>> pkg/usb_status_pkg.sv
// Purpose: Types shared by the USB status block and its surroundings
// Assumes: Engine signals are synchronous to clk_sys
// Notes: None
package usb_status_pkg;
  typedef struct packed {
    logic sof;
    logic stall_sent;
    logic trn_done;
    logic bus_reset;
    logic wb_valid;
    logic [4:0] wb_index;
    logic [3:0] wb_pid;
    logic [9:0] wb_count;
    logic [4:0] sel_index;
  } engine_event_t;
  typedef struct packed {
    logic owned;
    logic expected_toggle;
    logic toggle_check_enable;
    logic stall_request;
    logic [9:0] byte_count;
    logic [15:0] buffer_address;
  } descriptor_view_t;
  typedef enum logic [1:0] {
    LINE_ACTIVE = 2'b00,
    LINE_QUIET = 2'b01,
    LINE_IDLE = 2'b10
  } line_state_t;
endpackage
